// ===== rtl/clock_synth_control.sv
// frequency synthesizer control: register, dividers, loop model, clock muxes
// assumes the reference pin is asynchronous and the bus runs on clock_i;
// generated clocks are sampled levels, so they cannot exceed clock_i / 2
`timescale 1ns/100ps

// How it works
// - input divider divides the squared reference by value plus one
// - loop output is reference over (in+1), times 4 times (feedback+1)
// - a changed input divide value clears lock
// - a changed feedback divide value clears lock; lock returns after settling
// - clock-out select picks phase zero, reserved, reference or half reference
// - hardware reset clears the whole control register; clock-out shows phase 0
// - codec select picks input divider output or reference divided by 6.5
// - power-down bit stops the loop; clearing it restarts the loop
// - power-down cannot be set while the loop enable bit is set
// - setting power-down clears lock
// - enable set runs core from loop; clear runs core from reference
// - stop keeps an active loop; gates divider and clock-out if both off
// - all clocks come from the squared reference; phase zero trails core
// - lock is top bit, read-only, not cleared by clearing enable
// - reserved bits read as zero
module clock_synth_control (
	input wire logic clock_i, // 25 MHz system clock
	input wire logic rst_n_i, // async hardware reset, active low
	input wire logic reference_clock_pin_i, // external reference, async
	input wire logic clock_out_disable_i, // from operating mode register
	input wire logic stop_mode_i, // core is in stop mode
	input wire logic [clock_synth_pkg::ADDR_W-1:0] avs_address_i, // byte addr
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // high until the answer
	output logic core_clk_o, // core master clock
	output logic core_phase_zero_o, // delayed core clock
	output logic codec_clk_o, // codec clock
	output logic pll_ref_clk_o, // loop reference (input divider)
	output logic clock_out_pin_o, // clock-out pin
	output logic pll_power_down_o // loop is powered down
);
	import clock_synth_pkg::*;

	// reference synchroniser and edge events
	logic ref_s1_q;
	logic ref_s2_q;
	logic ref_s3_q;
	logic ref_rise;
	logic ref_edge;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
		end
		else
		begin
			ref_s1_q <= reference_clock_pin_i;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end

	assign ref_rise = ref_s2_q & ~ref_s3_q;
	assign ref_edge = ref_s2_q ^ ref_s3_q;

	// register bus slave: one wait cycle, then the answer
	logic waitreq_q;
	logic [31:0] rdata_q;
	logic [15:0] ctrl_q;
	logic lock_q;
	logic req;
	logic acc_en;
	logic wr_ctrl;
	logic [15:0] wr_merge;
	logic [15:0] ctrl_d;

	assign req = avs_read_i | avs_write_i;
	assign acc_en = req & ~waitreq_q;
	assign wr_ctrl = avs_write_i & ~waitreq_q & (avs_address_i == OFS_SYNTH_CTRL);

	always_comb
	begin
		wr_merge[7:0] = avs_byteenable_i[0] ? avs_writedata_i[7:0] : ctrl_q[7:0];
		wr_merge[15:8] = avs_byteenable_i[1] ? avs_writedata_i[15:8]
			: ctrl_q[15:8];
		ctrl_d = wr_merge & SYNTH_CTRL_WMASK;
		// power-down refused while the enable bit ends up set
		ctrl_d[PD_BIT] = wr_merge[PD_BIT] & ~wr_merge[EN_BIT];
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			waitreq_q <= 1'b1;
		else
			waitreq_q <= ~(req & waitreq_q);
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_q <= SYNTH_CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= ctrl_d;
	end

	// status word with the block's own state
	logic cur_pll_q;
	core_switch_e sw_q;
	logic gate_q;
	logic [15:0] period_q;
	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h00000000;
		status_word[ST_CORE_PLL_BIT] = cur_pll_q;
		status_word[ST_PARKED_BIT] = (sw_q == SW_PARK);
		status_word[ST_STOP_GATED_BIT] = gate_q;
		status_word[ST_REF_VALID_BIT] = (period_q != 16'h0000);
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 32'h00000000;
		else if (avs_read_i & waitreq_q)
		begin
			unique case (avs_address_i)
				OFS_SYNTH_CTRL: rdata_q <= {16'h0000, lock_q, ctrl_q[14:0]};
				OFS_SYNTH_STATUS: rdata_q <= status_word;
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	// lock model: settle count restarts on divider change or power-down
	logic div_changed;
	logic pd_set;
	logic [7:0] settle_q;

	assign div_changed = wr_ctrl
		& (ctrl_d[7:0] != ctrl_q[7:0]);
	assign pd_set = wr_ctrl & ctrl_d[PD_BIT] & ~ctrl_q[PD_BIT];

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			settle_q <= 8'h00;
			lock_q <= 1'b0;
		end
		else if (div_changed | pd_set | ctrl_q[PD_BIT])
		begin
			settle_q <= 8'h00;
			lock_q <= 1'b0;
		end
		else if (ref_rise & ~lock_q)
		begin
			if (settle_q == LOCK_SETTLE_REFS - 8'h01)
				lock_q <= 1'b1;
			else
				settle_q <= settle_q + 8'h01;
		end
	end

	// reference period in system cycles, measured on rising edges
	logic [15:0] per_cnt_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			per_cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end
		else if (ref_rise)
		begin
			period_q <= per_cnt_q + 16'h0001;
			per_cnt_q <= 16'h0000;
		end
		else if (per_cnt_q != 16'hFFFF)
			per_cnt_q <= per_cnt_q + 16'h0001;
	end

	// loop output model: toggles 8*(fb+1) times per (in+1)*period cycles,
	// so its rate is ref/(in+1) * 4 * (fb+1)
	logic [20:0] nco_den;
	logic [7:0] nco_step;
	logic [21:0] nco_acc_q;
	logic [21:0] nco_sum;
	logic pll_clk_q;

	assign nco_den = 21'(period_q)
		* 21'({1'b0, ctrl_q[IN_DIV_LSB +: 4]} + 5'h01);
	assign nco_step = {ctrl_q[FB_DIV_LSB +: 4] + 4'h1 == 4'h0 ? 5'h10
		: {1'b0, ctrl_q[FB_DIV_LSB +: 4] + 4'h1}, 3'b000};
	assign nco_sum = nco_acc_q + 22'(nco_step);

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			nco_acc_q <= 22'h000000;
			pll_clk_q <= 1'b0;
		end
		else if (ctrl_q[PD_BIT] | (period_q == 16'h0000))
		begin
			nco_acc_q <= 22'h000000;
			pll_clk_q <= 1'b0;
		end
		else if (nco_sum >= 22'(nco_den))
		begin
			nco_acc_q <= nco_sum - 22'(nco_den);
			pll_clk_q <= ~pll_clk_q;
		end
		else
			nco_acc_q <= nco_sum;
	end

	// stop entry decides whether divider and clock-out are gated
	logic stop_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stop_q <= 1'b0;
			gate_q <= 1'b0;
		end
		else
		begin
			stop_q <= stop_mode_i;
			if (!stop_mode_i)
				gate_q <= 1'b0;
			else if (!stop_q)
				gate_q <= ctrl_q[PD_BIT] & clock_out_disable_i;
		end
	end

	// input divider and the fixed 6.5 divider, both counting half periods
	event_div_if in_div ();
	event_div_if codec_div ();

	assign in_div.evt = ref_edge;
	assign in_div.hold = gate_q;
	assign in_div.limit = {1'b0, ctrl_q[IN_DIV_LSB +: 4]} + 5'h01;
	assign codec_div.evt = ref_edge;
	assign codec_div.hold = 1'b0;
	assign codec_div.limit = codec_div.out ? CODEC_DIV_SHORT
		: CODEC_DIV_LONG;

	event_divider u_in_div (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.div (in_div.divider)
	);

	event_divider u_codec_div (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.div (codec_div.divider)
	);

	logic codec_clk_q;
	logic pll_ref_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			codec_clk_q <= 1'b0;
			pll_ref_q <= 1'b0;
		end
		else
		begin
			// codec select never touches the loop reference
			codec_clk_q <= ctrl_q[CODEC_SEL_BIT] ? codec_div.out
				: in_div.out;
			pll_ref_q <= in_div.out;
		end
	end

	// glitch-free core clock switch: park low between sources
	logic src_cur;
	logic src_new;
	logic core_clk_q;

	assign src_cur = cur_pll_q ? pll_clk_q : ref_s2_q;
	assign src_new = ctrl_q[EN_BIT] ? pll_clk_q : ref_s2_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sw_q <= SW_RUN;
			cur_pll_q <= 1'b0;
			core_clk_q <= 1'b0;
		end
		else
		begin
			unique case (sw_q)
				SW_RUN:
				begin
					if ((ctrl_q[EN_BIT] != cur_pll_q) & ~src_cur & ~core_clk_q)
					begin
						sw_q <= SW_PARK;
						core_clk_q <= 1'b0;
					end
					else
						core_clk_q <= src_cur;
				end
				SW_PARK:
				begin
					core_clk_q <= 1'b0;
					if (~src_new)
					begin
						cur_pll_q <= ctrl_q[EN_BIT];
						sw_q <= SW_RUN;
					end
				end
				default:
				begin
					sw_q <= SW_PARK;
					core_clk_q <= 1'b0;
				end
			endcase
		end
	end

	// phase zero, half reference and clock-out pin
	logic phase0_q;
	logic ref_half_q;
	logic clko_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase0_q <= 1'b0;
			ref_half_q <= 1'b0;
		end
		else
		begin
			phase0_q <= core_clk_q;
			if (gate_q)
				ref_half_q <= 1'b0;
			else if (ref_rise)
				ref_half_q <= ~ref_half_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clko_q <= 1'b0;
		else if (clock_out_disable_i | gate_q)
			clko_q <= 1'b0;
		else
		begin
			unique case (ctrl_q[CLKO_SEL_LSB +: 2])
				CLKO_PHASE0: clko_q <= phase0_q;
				CLKO_RESERVED: clko_q <= 1'b0;
				CLKO_REF: clko_q <= ref_s2_q;
				CLKO_REF_HALF: clko_q <= ref_half_q;
			endcase
		end
	end

	logic pd_out_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pd_out_q <= 1'b0;
		else
			pd_out_q <= ctrl_q[PD_BIT];
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = waitreq_q;
	assign core_clk_o = core_clk_q;
	assign core_phase_zero_o = phase0_q;
	assign codec_clk_o = codec_clk_q;
	assign pll_ref_clk_o = pll_ref_q;
	assign clock_out_pin_o = clko_q;
	assign pll_power_down_o = pd_out_q;

endmodule : clock_synth_control

// ===== common/clock_synth_pkg.sv
// constants, field layout and types of the frequency synthesizer control
// assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus
package clock_synth_pkg;

	localparam int unsigned CLK_FREQ_HZ = 25000000;
	localparam int ADDR_W = 4;

	// byte offsets of the register words
	localparam logic [3:0] OFS_SYNTH_CTRL = 4'h0;
	localparam logic [3:0] OFS_SYNTH_STATUS = 4'h4;

	// freq_synth_control fields
	localparam int IN_DIV_LSB = 0;
	localparam int FB_DIV_LSB = 4;
	localparam int CLKO_SEL_LSB = 10;
	localparam int CODEC_SEL_BIT = 12;
	localparam int PD_BIT = 13;
	localparam int EN_BIT = 14;
	localparam int LOCK_BIT = 15;
	localparam logic [15:0] SYNTH_CTRL_RST = 16'h0000;
	localparam logic [15:0] SYNTH_CTRL_WMASK = 16'h7CFF;

	// own status word bits
	localparam int ST_CORE_PLL_BIT = 0;
	localparam int ST_PARKED_BIT = 1;
	localparam int ST_STOP_GATED_BIT = 2;
	localparam int ST_REF_VALID_BIT = 3;

	// clock-out source codes
	localparam logic [1:0] CLKO_PHASE0 = 2'h0;
	localparam logic [1:0] CLKO_RESERVED = 2'h1;
	localparam logic [1:0] CLKO_REF = 2'h2;
	localparam logic [1:0] CLKO_REF_HALF = 2'h3;

	// reference cycles the loop model needs to settle
	localparam logic [7:0] LOCK_SETTLE_REFS = 8'h40;
	// the 6.5 divider alternates these half-period counts (7 + 6 = 13)
	localparam logic [4:0] CODEC_DIV_LONG = 5'h07;
	localparam logic [4:0] CODEC_DIV_SHORT = 5'h06;

	typedef enum logic [1:0] {
		SW_RUN = 2'b01,
		SW_PARK = 2'b10
	} core_switch_e;

endpackage : clock_synth_pkg

// ===== common/event_div_if.sv
// signals between the synthesizer control and one event divider
// assumes one clock domain; evt is a one-cycle pulse
`timescale 1ns/100ps
interface event_div_if;
	logic evt;
	logic hold;
	logic [4:0] limit;
	logic out;

	modport divider (input evt, input hold, input limit, output out);
	modport user (output evt, output hold, output limit, input out);
endinterface : event_div_if

// ===== rtl/event_divider.sv
// divider that toggles its output every limit input events
// assumes limit is at least one and events are single-cycle pulses
`timescale 1ns/100ps
module event_divider (
	input wire logic clock_i, // system clock
	input wire logic rst_n_i, // async reset, active low
	event_div_if.divider div // events in, divided level out
);
	import clock_synth_pkg::*;

	logic [4:0] cnt_q;
	logic out_q;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 5'h00;
			out_q <= 1'b0;
		end
		else if (div.hold)
		begin
			// held (gated in stop): park low, restart cleanly
			cnt_q <= 5'h00;
			out_q <= 1'b0;
		end
		else if (div.evt)
		begin
			if (cnt_q + 5'h01 >= div.limit)
			begin
				cnt_q <= 5'h00;
				out_q <= ~out_q;
			end
			else
			begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	assign div.out = out_q;

endmodule : event_divider

// ===== bench/ref_clock_source.sv
// free-running external reference that feeds the reference pin
// assumes no relation in phase to the system clock
`timescale 1ns/100ps
module ref_clock_source #(
	parameter time HALF_PERIOD = 160ns
) (
	output logic ref_clk_o // reference level
);
	initial
	begin
		ref_clk_o = 1'b0;
		#7;
		forever #(HALF_PERIOD) ref_clk_o = ~ref_clk_o;
	end
endmodule : ref_clock_source

// ===== bench/clock_synth_control_assertions.sv
// port-level checks of the synthesizer control block
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
module clock_synth_control_assertions
	import clock_synth_pkg::*;
(
	input wire logic clock_i, // system clock
	input wire logic rst_n_i, // reset, active low
	input wire logic clock_out_disable_i, // clock-out off
	input wire logic stop_mode_i, // stop mode
	input wire logic [ADDR_W-1:0] avs_address_i, // address
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // lanes
	input wire logic [31:0] avs_readdata_o, // read data
	input wire logic avs_waitrequest_o, // wait
	input wire logic core_clk_o, // core clock
	input wire logic core_phase_zero_o, // phase zero
	input wire logic pll_ref_clk_o, // loop reference
	input wire logic clock_out_pin_o, // clock-out
	input wire logic pll_power_down_o // power down
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_wait_answer: assert property ((avs_read_i || avs_write_i)
		&& avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered after one cycle");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer longer than one cycle");
	a_pd_refused: assert property (avs_write_i && !avs_waitrequest_o
		&& avs_address_i == OFS_SYNTH_CTRL && avs_byteenable_i[1]
		&& avs_writedata_i[EN_BIT] |-> ##2 !pll_power_down_o)
		else $error("power down accepted with enable set");
	a_pd_taken: assert property (avs_write_i && !avs_waitrequest_o
		&& avs_address_i == OFS_SYNTH_CTRL && avs_byteenable_i[1]
		&& avs_writedata_i[PD_BIT] && !avs_writedata_i[EN_BIT]
		|-> ##2 pll_power_down_o)
		else $error("power down not applied");
	a_phase_trails: assert property (core_phase_zero_o == $past(core_clk_o))
		else $error("phase zero not one cycle behind core");
	a_clko_off: assert property (clock_out_disable_i [*3] |-> !clock_out_pin_o)
		else $error("clock-out active while disabled");
	a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
		|-> avs_readdata_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_reserved_zero: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i == OFS_SYNTH_CTRL |-> avs_readdata_o[9:8] == 2'h0)
		else $error("reserved bits not zero");
	a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i != OFS_SYNTH_CTRL && avs_address_i != OFS_SYNTH_STATUS
		|-> avs_readdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_stop_gated: assert property ($rose(stop_mode_i) && pll_power_down_o
		&& clock_out_disable_i |-> ##4 (!pll_ref_clk_o && !clock_out_pin_o) [*4])
		else $error("divider not gated in stop");
endmodule : clock_synth_control_assertions

bind clock_synth_control clock_synth_control_assertions chk_u (.clock_i,
	.rst_n_i, .clock_out_disable_i, .stop_mode_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .core_clk_o, .core_phase_zero_o, .pll_ref_clk_o,
	.clock_out_pin_o, .pll_power_down_o);

// ===== bench/clock_synth_control_tb_top.sv
// register-driven test of the synthesizer control with a reference source
// assumes a 25 MHz clock and a reference of eight clock periods
`timescale 1ns/100ps
module clock_synth_control_tb_top;
	import clock_synth_pkg::*;
	logic clock_i, rst_n_i, reference_clock_pin_i, clock_out_disable_i;
	logic stop_mode_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [ADDR_W-1:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0] avs_byteenable_i;
	logic core_clk_o, core_phase_zero_o, codec_clk_o, pll_ref_clk_o;
	logic clock_out_pin_o, pll_power_down_o;
	int mismatches = 0;
	int n_tests = 0;
	int cnt [4];
	// rises in 512 cycles: core, loop reference, codec, clock-out
	logic [15:0] cfg [5] = '{16'h1401, 16'h0801, 16'h0C01, 16'h4001, 16'h4001};
	int exp_tab [5][4] = '{'{64, 32, 10, 0}, '{64, 32, 32, 64},
		'{64, 32, 32, 32}, '{128, 32, 32, 128}, '{128, 32, 32, 0}};

	ref_clock_source ref_u (.ref_clk_o(reference_clock_pin_i));
	clock_synth_control dut_u (.clock_i, .rst_n_i, .reference_clock_pin_i,
		.clock_out_disable_i, .stop_mode_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .core_clk_o, .core_phase_zero_o, .codec_clk_o,
		.pll_ref_clk_o, .clock_out_pin_o, .pll_power_down_o);

	initial
	begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	task finish_test(input bit hang);
		if (hang)
			mismatches++;
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask : check

	task count_chk(input int e, input int g);
		n_tests++;
		if (g < e - 1 || g > e + 1)
		begin
			mismatches++;
			$display("MISMATCH rise count exp %0d got %0d", e, g);
		end
	endtask : count_chk

	task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
		int k;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= {16'h0000, d};
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		k = 0;
		do
		begin
			@(posedge clock_i);
			k++;
		end
		while (avs_waitrequest_o !== 1'b0 && k < 50);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (k >= 50)
			finish_test(1'b1);
	endtask : bus

	task rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0000);
		check("readdata", e, rd);
	endtask : rdchk

	task wait_lock;
		int i;
		i = 0;
		do
		begin
			repeat (16) @(posedge clock_i);
			bus(1'b0, OFS_SYNTH_CTRL, 16'h0000);
			i++;
		end
		while (rd[LOCK_BIT] !== 1'b1 && i < 200);
		check("lock", 32'h1, {31'h0, rd[LOCK_BIT]});
		if (i >= 200)
			finish_test(1'b1);
	endtask : wait_lock

	// counts rising levels of the generated clocks over 512 cycles
	task measure;
		logic [3:0] p, s;
		p = 4'h0;
		cnt = '{0, 0, 0, 0};
		repeat (512)
		begin
			@(posedge clock_i);
			s = {clock_out_pin_o, codec_clk_o, pll_ref_clk_o, core_clk_o};
			for (int j = 0; j < 4; j++)
				if (s[j] && !p[j])
					cnt[j]++;
			p = s;
		end
	endtask : measure

	initial
	begin
		rst_n_i = 1'b0;
		clock_out_disable_i = 1'b0;
		stop_mode_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 4'h0;
		avs_writedata_i = 32'h0000_0000;
		avs_byteenable_i = 4'h3;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rdchk(OFS_SYNTH_CTRL, 32'h0000_0000);
		rdchk(4'h8, 32'h0000_0000);
		bus(1'b1, OFS_SYNTH_CTRL, 16'hFFFF);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_5CFF);
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0000);
		bus(1'b1, OFS_SYNTH_CTRL, 16'h2000);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_2000);
		check("power down", 32'h1, {31'h0, pll_power_down_o});
		clock_out_disable_i <= 1'b1;
		stop_mode_i <= 1'b1;
		measure;
		count_chk(0, cnt[1]);
		stop_mode_i <= 1'b0;
		clock_out_disable_i <= 1'b0;
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0001);
		wait_lock;
		bus(1'b1, OFS_SYNTH_CTRL, 16'h4001);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_C001);
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0001);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_8001);
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0011);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_0011);
		wait_lock;
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0010);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_0010);
		wait_lock;
		bus(1'b1, OFS_SYNTH_CTRL, 16'h2010);
		rdchk(OFS_SYNTH_CTRL, 32'h0000_2010);
		bus(1'b1, OFS_SYNTH_CTRL, 16'h0001);
		wait_lock;
		for (int i = 0; i < 5; i++)
		begin
			clock_out_disable_i <= (i == 4);
			bus(1'b1, OFS_SYNTH_CTRL, cfg[i]);
			repeat (64) @(posedge clock_i);
			measure;
			for (int j = 0; j < 4; j++)
				count_chk(exp_tab[i][j], cnt[j]);
		end
		// core on the loop, switch settled, not gated, reference measured
		rdchk(OFS_SYNTH_STATUS, 32'h0000_0009);
		finish_test(1'b0);
	end
endmodule : clock_synth_control_tb_top
